// ==== hdl/dual_timer_regs.vh ====
// Register offsets, field positions, reset values and timing counts of the dual timer.
// Assumes APB byte addresses with one aligned 32-bit word per register.
`ifndef DUAL_TIMER_REGS_VH
`define DUAL_TIMER_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_AUX_CTRL   8'h00
`define OFS_CORE_CTRL  8'h04
`define OFS_AUX_COUNT  8'h08
`define OFS_CORE_COUNT 8'h0C
`define OFS_CAPTURE_RELOAD_REGISTER     8'h10
`define OFS_CAP_CTRL   8'h14
`define OFS_STATUS     8'h18
`define OFS_MASK       8'h1C

// ----------------------------------------------------------------------------
// Timer control fields (shared by both timer control registers, except the latch state bit, which only the core control register has)
// ----------------------------------------------------------------------------
`define TC_RUN        0
`define TC_DOWN       1
`define TC_EXT_DIR    2
`define TC_SRC_LO     3
`define TC_SRC_HI     4
`define TC_PRE_LO     5
`define TC_PRE_HI     7
`define TC_EDGE_LO    8
`define TC_EDGE_HI    9
`define TC_RELOAD     10
`define TC_LATCH_OUT  11
`define TC_LATCH_STATE 12
`define TC_WIDTH      12

// Clock source codes.
`define SRC_PRESCALER 2'h0
`define SRC_PIN       2'h1
`define SRC_LATCH     2'h2

// ----------------------------------------------------------------------------
// Capture control fields
// ----------------------------------------------------------------------------
`define CC_EDGE_LO    0
`define CC_EDGE_HI    1
`define CC_CLEAR      2
`define CC_FM_COUNT   3
`define CC_FM_DIR     4
`define CC_WIDTH      5

// ----------------------------------------------------------------------------
// Status and mask bits
// ----------------------------------------------------------------------------
`define ST_AUX_WRAP   0
`define ST_CORE_WRAP  1
`define ST_CAPTURE    2
`define ST_WIDTH      3

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define RST_TIMER_CTRL 12'h000
`define RST_CAP_CTRL   5'h00
`define RST_COUNT      16'h0000
`define MIN_TICK_CYCLES 2

`endif

// ==== hdl/edge_select.v ====
// Edge detector with selectable rising, falling or both edges.
// Assumes the input is already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none

module edge_select (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       level,
    input  wire [1:0] sel,
    output wire       pulse
);

    reg prev;

    // ------------------------------------------------------------------------
    // Previous level store
    // ------------------------------------------------------------------------
    // The history starts low, so a pin held high at reset gives one rising edge.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 1'b0;
        end else begin
            prev <= level;
        end
    end

    // Bit 0 selects rising edges, bit 1 falling edges.
    assign pulse = (sel[0] & level & ~prev) | (sel[1] & ~level & prev);

endmodule // edge_select

`default_nettype wire

// ==== hdl/tick_prescaler.v ====
// Free-running prescaler giving a one-cycle tick every 2^(sel+1) clocks.
// Assumes one clock domain; the shortest period is two clocks.
`timescale 1ns/1ps
`default_nettype none

module tick_prescaler #(
    parameter WIDTH = 8
) (
    input  wire       clk,
    input  wire       rst_n,
    input  wire [2:0] sel,
    output wire       tick
);

    reg  [WIDTH-1:0] count;
    wire [WIDTH-1:0] mask;

    // ------------------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------------------
    // The counter is shared by all settings, so a new setting takes effect
    // without restarting it; the first period after a change may be short.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= {WIDTH{1'b0}};
        end else begin
            count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // Low sel+1 bits set form the mask; tick when all of them are ones.
    assign mask = ~({WIDTH{1'b1}} << ({{(WIDTH-3){1'b0}}, sel} + {{(WIDTH-1){1'b0}}, 1'b1}));
    assign tick = &(count | ~mask);

endmodule // tick_prescaler

`default_nettype wire

// ==== hdl/dual_timer_capture_reload.v ====
// Dual 16-bit up/down timer with toggle latch and capture/reload register, APB slave.
// Assumes all pins are synchronous to pclk and stable for two clocks per level.
//
// Behaviour
// (RL1) Finest timer tick is two clocks.
// (RL2) Both timers and capture register sixteen bits.
// (RL3) Auxiliary timer, core timer, one capture/reload register.
// (RL4) Clock from prescaler or external pins.
// (RL5) Direction by software or direction pin level.
// (RL6) Toggle latch flips on core wrap.
// (RL7) Latch clocks auxiliary timer and/or drives pin.
// (RL8) Core wraps offered as neighbour count clock.
// (RL9) Core wrap may reload from capture register.
// (RL10) Capture pin edge copies auxiliary count.
// (RL11) Optional clear of auxiliary timer after capture.
// (RL12) Capture also from first-module count/direction inputs.
// (RL13) Wraps and captures set readable request flags.
// (RL14) Outside signals synchronous, stable two clocks.
//
// Decided for this implementation: the register addresses and the APB register port.
`include "dual_timer_regs.vh"
`timescale 1ns/1ps
`default_nettype none

module dual_timer_capture_reload #(
    parameter PRESCALE_WIDTH = 8
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata,
    input  wire        aux_count_pin,
    input  wire        core_count_pin,
    input  wire        aux_direction_control_pin,
    input  wire        core_direction_control_pin,
    input  wire        capture_input_pin,
    input  wire        first_module_count_input,
    input  wire        first_module_direction_input,
    output wire        toggle_latch_output_pin,
    output wire        core_wrap_clock,
    output wire        irq
);

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    reg  [`TC_WIDTH-1:0] aux_ctrl;
    reg  [`TC_WIDTH-1:0] core_ctrl;
    reg  [`CC_WIDTH-1:0] cap_ctrl;
    reg  [15:0]          aux_timer;
    reg  [15:0]          core_timer;
    reg  [15:0]          capture_reload_register;
    reg                  core_toggle_latch;
    reg  [`ST_WIDTH-1:0] status;
    reg  [`ST_WIDTH-1:0] mask;
    reg  [31:0]          next_prdata;
    reg                  addr_hit;
    wire                 setup;
    wire                 wr;
    wire                 aux_pre_tick;
    wire                 core_pre_tick;
    wire                 aux_pin_edge;
    wire                 core_pin_edge;
    wire                 latch_edge;
    wire                 capture_input_pin_edge;
    wire                 fm_count_edge;
    wire                 fm_dir_edge;
    wire                 aux_tick;
    wire                 core_tick;
    wire                 aux_down;
    wire                 core_down;
    wire                 aux_wrap;
    wire                 core_wrap;
    wire                 capture;
    wire [`ST_WIDTH-1:0] events;

    // ------------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------------
    // Count step shared by both timers.
    function [15:0] step;
        input [15:0] value;
        input        down;
        begin
            step = down ? value - 16'h0001 : value + 16'h0001;
        end
    endfunction

    // Wrap detection shared by both timers: all ones going up, zero going down.
    function wraps;
        input [15:0] value;
        input        down;
        begin
            wraps = down ? (value == 16'h0000) : (value == 16'hFFFF);
        end
    endfunction

    // Tick selection shared by both timers.
    function pick_tick;
        input [1:0] src;
        input       pre;
        input       pin;
        input       latch;
        input       allow_latch;
        begin
            case (src)
                `SRC_PRESCALER: pick_tick = pre;
                `SRC_PIN:       pick_tick = pin;
                `SRC_LATCH:     pick_tick = latch & allow_latch;
                default:        pick_tick = 1'b0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------------
    // Clock sources
    // ------------------------------------------------------------------------
    // Each timer has its own prescaler so the two may run at different rates.
    tick_prescaler #(.WIDTH(PRESCALE_WIDTH)) u_aux_pre (
        .clk   (pclk),
        .rst_n (presetn),
        .sel   (aux_ctrl[`TC_PRE_HI:`TC_PRE_LO]),
        .tick  (aux_pre_tick)
    ); // [RL1] [RL4]

    tick_prescaler #(.WIDTH(PRESCALE_WIDTH)) u_core_pre (
        .clk   (pclk),
        .rst_n (presetn),
        .sel   (core_ctrl[`TC_PRE_HI:`TC_PRE_LO]),
        .tick  (core_pre_tick)
    ); // [RL1] [RL4]

    edge_select u_aux_pin (
        .clk   (pclk),
        .rst_n (presetn),
        .level (aux_count_pin),
        .sel   (aux_ctrl[`TC_EDGE_HI:`TC_EDGE_LO]),
        .pulse (aux_pin_edge)
    ); // [RL4]

    edge_select u_core_pin (
        .clk   (pclk),
        .rst_n (presetn),
        .level (core_count_pin),
        .sel   (core_ctrl[`TC_EDGE_HI:`TC_EDGE_LO]),
        .pulse (core_pin_edge)
    ); // [RL4]

    // The latch edges that clock the auxiliary timer use its own edge field.
    edge_select u_latch (
        .clk   (pclk),
        .rst_n (presetn),
        .level (core_toggle_latch),
        .sel   (aux_ctrl[`TC_EDGE_HI:`TC_EDGE_LO]),
        .pulse (latch_edge)
    ); // [RL7]

    edge_select u_capture_input_pin (
        .clk   (pclk),
        .rst_n (presetn),
        .level (capture_input_pin),
        .sel   (cap_ctrl[`CC_EDGE_HI:`CC_EDGE_LO]),
        .pulse (capture_input_pin_edge)
    ); // [RL10]

    edge_select u_fm_count (
        .clk   (pclk),
        .rst_n (presetn),
        .level (first_module_count_input),
        .sel   ({2{cap_ctrl[`CC_FM_COUNT]}}),
        .pulse (fm_count_edge)
    ); // [RL12]

    edge_select u_fm_dir (
        .clk   (pclk),
        .rst_n (presetn),
        .level (first_module_direction_input),
        .sel   ({2{cap_ctrl[`CC_FM_DIR]}}),
        .pulse (fm_dir_edge)
    ); // [RL12]

    // ------------------------------------------------------------------------
    // Tick, direction and event decode
    // ------------------------------------------------------------------------
    // A stopped timer ignores every tick. Only the auxiliary timer may take the latch.
    assign aux_tick  = aux_ctrl[`TC_RUN] &
                       pick_tick(aux_ctrl[`TC_SRC_HI:`TC_SRC_LO], aux_pre_tick,
                                 aux_pin_edge, latch_edge, 1'b1); // [RL4] [RL7]
    assign core_tick = core_ctrl[`TC_RUN] &
                       pick_tick(core_ctrl[`TC_SRC_HI:`TC_SRC_LO], core_pre_tick,
                                 core_pin_edge, 1'b0, 1'b0); // [RL4]

    // A high direction pin inverts the software direction when enabled.
    assign aux_down  = aux_ctrl[`TC_DOWN] ^ (aux_ctrl[`TC_EXT_DIR] & aux_direction_control_pin); // [RL5]
    assign core_down = core_ctrl[`TC_DOWN] ^ (core_ctrl[`TC_EXT_DIR] & core_direction_control_pin); // [RL5]

    assign aux_wrap  = aux_tick & wraps(aux_timer, aux_down);
    assign core_wrap = core_tick & wraps(core_timer, core_down); // [RL6]

    // Any selected capture source triggers; they are ORed, not prioritised.
    assign capture = capture_input_pin_edge | fm_count_edge | fm_dir_edge; // [RL10] [RL12]

    assign events = {capture, core_wrap, aux_wrap}; // [RL13]

    // ------------------------------------------------------------------------
    // Auxiliary timer
    // ------------------------------------------------------------------------
    // Software write wins, then the clear after capture, then a count tick.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_timer <= `RST_COUNT;
        end else if (wr && paddr == `OFS_AUX_COUNT) begin
            aux_timer <= pwdata[15:0];
        end else if (capture && cap_ctrl[`CC_CLEAR]) begin
            aux_timer <= 16'h0000; // [RL11]
        end else if (aux_tick) begin
            aux_timer <= step(aux_timer, aux_down); // [RL2] [RL3]
        end
    end

    // ------------------------------------------------------------------------
    // Core timer and toggle latch
    // ------------------------------------------------------------------------
    // On a wrap with reload enabled the capture register value is loaded.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_timer <= `RST_COUNT;
        end else if (wr && paddr == `OFS_CORE_COUNT) begin
            core_timer <= pwdata[15:0];
        end else if (core_wrap && core_ctrl[`TC_RELOAD]) begin
            core_timer <= capture_reload_register; // [RL9]
        end else if (core_tick) begin
            core_timer <= step(core_timer, core_down); // [RL2] [RL3]
        end
    end

    // Software may preset the latch through the core control state bit.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_toggle_latch <= 1'b0;
        end else if (core_wrap) begin
            core_toggle_latch <= ~core_toggle_latch; // [RL6]
        end else if (wr && paddr == `OFS_CORE_CTRL) begin
            core_toggle_latch <= pwdata[`TC_LATCH_STATE];
        end
    end

    // The pin rests low while the output is disabled.
    assign toggle_latch_output_pin = core_toggle_latch & core_ctrl[`TC_LATCH_OUT]; // [RL7]
    assign core_wrap_clock = core_wrap; // [RL8]

    // ------------------------------------------------------------------------
    // Capture/reload register
    // ------------------------------------------------------------------------
    // A capture beats a software write in the same cycle, so no event is lost.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_reload_register <= `RST_COUNT;
        end else if (capture) begin
            capture_reload_register <= aux_timer; // [RL10]
        end else if (wr && paddr == `OFS_CAPTURE_RELOAD_REGISTER) begin
            capture_reload_register <= pwdata[15:0];
        end
    end

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_ctrl  <= `RST_TIMER_CTRL;
            core_ctrl <= `RST_TIMER_CTRL;
            cap_ctrl  <= `RST_CAP_CTRL;
            mask      <= {`ST_WIDTH{1'b0}};
        end else if (wr) begin
            case (paddr)
                `OFS_AUX_CTRL:  aux_ctrl  <= pwdata[`TC_WIDTH-1:0];
                `OFS_CORE_CTRL: core_ctrl <= pwdata[`TC_WIDTH-1:0];
                `OFS_CAP_CTRL:  cap_ctrl  <= pwdata[`CC_WIDTH-1:0];
                `OFS_MASK:      mask      <= pwdata[`ST_WIDTH-1:0];
                default:        mask      <= mask;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Status flags and interrupt
    // ------------------------------------------------------------------------
    // Write one to clear; a new event in the clearing cycle keeps its flag set.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= {`ST_WIDTH{1'b0}};
        end else if (wr && paddr == `OFS_STATUS) begin
            status <= (status & ~pwdata[`ST_WIDTH-1:0]) | events; // [RL13]
        end else begin
            status <= status | events; // [RL13]
        end
    end

    assign irq = |(status & mask);

    // ------------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------------
    // Zero wait states: the access phase always completes at its first edge.
    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pwrite & addr_hit;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addr_hit;

    // Read mux and address decode.
    always @* begin
        next_prdata = 32'h00000000;
        addr_hit    = 1'b1;
        case (paddr)
            `OFS_AUX_CTRL:   next_prdata[`TC_WIDTH-1:0] = aux_ctrl;
            `OFS_CORE_CTRL:  next_prdata[`TC_WIDTH:0]   = {core_toggle_latch, core_ctrl};
            `OFS_AUX_COUNT:  next_prdata[15:0]          = aux_timer;
            `OFS_CORE_COUNT: next_prdata[15:0]          = core_timer;
            `OFS_CAPTURE_RELOAD_REGISTER:     next_prdata[15:0]          = capture_reload_register;
            `OFS_CAP_CTRL:   next_prdata[`CC_WIDTH-1:0] = cap_ctrl;
            `OFS_STATUS:     next_prdata[`ST_WIDTH-1:0] = status;
            `OFS_MASK:       next_prdata[`ST_WIDTH-1:0] = mask;
            default:         addr_hit = 1'b0;
        endcase
    end

    // Read data is sampled in the setup cycle so it stands through the access.
    // The trade-off is that a read shows the value of the setup cycle.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (setup) begin
            prdata <= next_prdata;
        end
    end

endmodule // dual_timer_capture_reload

`default_nettype wire

// ==== tb/dual_timer_chk.sv ====
// Port checker for the dual timer, bound to every instance.
// Assumes one clock domain and the APB map of the register header.
`timescale 1ns/1ps
`default_nettype none
module dual_timer_chk (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    input wire logic        toggle_latch_output_pin,
    input wire logic        core_wrap_clock,
    input wire logic        irq
);
    // ------------------------------------------------------------------
    // Relations between the ports
    // ------------------------------------------------------------------
    // A write is the only software cause of a latch pin or interrupt change, so it is the excuse that other causes need.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    pready_high_a: assert property (pready)
        else $error("pready low");
    slverr_map_a: assert property (psel && penable && paddr > 8'h1C |-> pslverr)
        else $error("unmapped access not flagged");
    slverr_phase_a: assert property (pslverr |-> psel && penable && paddr > 8'h1C)
        else $error("error flag outside unmapped access");
    err_rdata_zero_a: assert property (pslverr |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (prdata[31:16] == 16'h0)
        else $error("read data wider than sixteen bits");
    wrap_pulse_a: assert property (core_wrap_clock |=> !core_wrap_clock)
        else $error("wrap clock longer than one cycle");
    latch_cause_a: assert property ($changed(toggle_latch_output_pin) |->
        $past(core_wrap_clock) || $past(psel && penable && pwrite))
        else $error("latch pin changed without wrap or write");
    irq_fall_a: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
        else $error("interrupt dropped without a write");
    reset_quiet_a: assert property ($rose(presetn) |-> !irq && !core_wrap_clock && !toggle_latch_output_pin)
        else $error("outputs active at reset release");
endmodule // dual_timer_chk

bind dual_timer_capture_reload dual_timer_chk i_dual_timer_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .toggle_latch_output_pin(toggle_latch_output_pin), .core_wrap_clock(core_wrap_clock), .irq(irq));
`default_nettype wire

// ==== tb/ext_pins.sv ====
// Model of the port pins that drive the timer's external inputs.
// Assumes pins are already synchronous; pin order is fixed by the bench.
`timescale 1ns/1ps
`default_nettype none
module ext_pins #(
    parameter int HOLD = 2
) (
    input  wire logic       pclk,
    output wire logic [6:0] pins
);
    logic [6:0] lvl = 7'h00;

    // ------------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------------
    // Levels change only after a rising edge, so the device never samples a half-made transition.
    assign pins = lvl;

    // One high and one low level, each held HOLD clocks; HOLD below two would be illegal.
    task automatic pulse(input int idx);
        @(posedge pclk);
        lvl[idx] <= 1'b1;
        repeat (HOLD) @(posedge pclk);
        lvl[idx] <= 1'b0;
        repeat (HOLD) @(posedge pclk);
    endtask

    // Static level, settled for HOLD clocks before anyone relies on it.
    task automatic level(input int idx, input logic v);
        @(posedge pclk);
        lvl[idx] <= v;
        repeat (HOLD) @(posedge pclk);
    endtask
endmodule // ext_pins
`default_nettype wire

// ==== tb/dual_timer_capture_reload_bench.sv ====
// Self-checking bench for the dual timer: APB master, pin model and checker.
// Assumes the register map and field positions of the register header.
`include "dual_timer_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module dual_timer_capture_reload_bench;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    wire         pready, pslverr, tl_pin, wrap_clk, irq;
    wire  [31:0] prdata;
    wire  [6:0]  pin;
    int          num_errors = 0;
    int          total_checks = 0;
    int          cyc = 0;
    int          wraps = 0;
    logic [31:0] r;
    logic        e;
    logic [4:0]  cc [4] = '{5'h02, 5'h05, 5'h08, 5'h10};
    int          pidx [4] = '{4, 4, 5, 6};

    dual_timer_capture_reload i_dual_timer_capture_reload (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .aux_count_pin(pin[0]), .core_count_pin(pin[1]), .aux_direction_control_pin(pin[2]),
        .core_direction_control_pin(pin[3]), .capture_input_pin(pin[4]),
        .first_module_count_input(pin[5]), .first_module_direction_input(pin[6]),
        .toggle_latch_output_pin(tl_pin), .core_wrap_clock(wrap_clk), .irq(irq));
    ext_pins #(.HOLD(3)) i_ext_pins (.pclk(pclk), .pins(pin));

    // ------------------------------------------------------------------
    // Clock, watchdog and wrap counter
    // ------------------------------------------------------------------
    always #25 pclk = ~pclk;

    // Counts wrap pulses and cuts a hang short well after the planned run.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (wrap_clk === 1'b1) wraps <= wraps + 1;
        if (cyc == 40000) begin
            num_errors++;
            summarize();
        end
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One APB transfer; an idle edge at the end lets outputs settle before they are checked.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task automatic summarize;
        if (num_errors == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int v, k, p, t;
        void'($urandom(32'hB271));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        // Every register reads zero after reset; the word past the map is refused.
        for (int a = 0; a < 36; a += 4) begin
            rd(a[7:0]);
            check("reset", r, 32'h0);
            check("slverr", {31'h0, e}, {31'h0, a == 32});
        end
        // Prescaler rates; the free-running phase allows one tick either way.
        for (int n = 0; n < 3; n++) begin
            p = 2 << n;
            t = 8 + 3 / p;
            wr(`OFS_AUX_COUNT, 32'h0);
            wr(`OFS_AUX_CTRL, 32'h1 | (n << 5));
            repeat (8 * p) @(posedge pclk);
            wr(`OFS_AUX_CTRL, 32'h0);
            rd(`OFS_AUX_COUNT);
            check("prescale", r >= t - 1 && r <= t + 1, 32'h1);
        end
        // Pin counting in every mix of software and pin direction.
        for (int m = 0; m < 8; m++) begin
            v = $urandom;
            k = $urandom_range(3, 1);
            wr(`OFS_AUX_COUNT, {16'h0, v[15:0]});
            i_ext_pins.level(2, m[2]);
            wr(`OFS_AUX_CTRL, 32'h109 | (m[1:0] << 1));
            repeat (k) i_ext_pins.pulse(0);
            wr(`OFS_AUX_CTRL, 32'h0);
            rd(`OFS_AUX_COUNT);
            check("updown", r, {16'h0, (m[0] ^ (m[1] & m[2])) ? v[15:0] - k[15:0] : v[15:0] + k[15:0]});
        end
        i_ext_pins.level(2, 1'b0);
        // Core overflow with reload, masked then unmasked interrupt.
        wr(`OFS_STATUS, 32'h7);
        wr(`OFS_MASK, 32'h0);
        wr(`OFS_CAPTURE_RELOAD_REGISTER, 32'h1234);
        wr(`OFS_CORE_COUNT, 32'hFFFE);
        wr(`OFS_CORE_CTRL, 32'hD09);
        k = wraps;
        repeat (2) i_ext_pins.pulse(1);
        check("wrapclk", wraps - k, 32'h1);
        check("latch", tl_pin, 1'b1);
        check("irqmask", irq, 1'b0);
        rd(`OFS_CORE_COUNT);
        check("reload", r, 32'h1234);
        rd(`OFS_STATUS);
        check("status", r, 32'h2);
        wr(`OFS_MASK, 32'h2);
        check("irq", irq, 1'b1);
        wr(`OFS_STATUS, 32'h2);
        check("irqclr", irq, 1'b0);
        // Underflow; the preset latch rises again and clocks the chained timer once.
        wr(`OFS_CORE_COUNT, 32'h0);
        wr(`OFS_CORE_CTRL, 32'h90B);
        wr(`OFS_AUX_COUNT, 32'h0);
        wr(`OFS_AUX_CTRL, 32'h311);
        i_ext_pins.pulse(1);
        check("latch", tl_pin, 1'b1);
        rd(`OFS_CORE_COUNT);
        check("under", r, 32'hFFFF);
        rd(`OFS_AUX_COUNT);
        check("chain", r, 32'h1);
        wr(`OFS_AUX_CTRL, 32'h0);
        wr(`OFS_CORE_CTRL, 32'h0);
        // Every capture source, with and without clearing.
        for (int s = 0; s < 4; s++) begin
            v = $urandom;
            wr(`OFS_AUX_COUNT, {16'h0, v[15:0]});
            wr(`OFS_CAP_CTRL, {27'h0, cc[s]});
            wr(`OFS_STATUS, 32'h7);
            i_ext_pins.pulse(pidx[s]);
            wr(`OFS_CAP_CTRL, 32'h0);
            rd(`OFS_CAPTURE_RELOAD_REGISTER);
            check("capture", r, {16'h0, v[15:0]});
            rd(`OFS_AUX_COUNT);
            check("clear", r, (s == 1) ? 32'h0 : {16'h0, v[15:0]});
            rd(`OFS_STATUS);
            check("capflag", r, 32'h4);
        end
        summarize();
    end
endmodule // dual_timer_capture_reload_bench
`default_nettype wire
